// ===== irq_ctl_consts.svh
/*
  Offsets, field positions, reset values and widths of the interrupt
  control and flag block. Definitions only; included by the package
  and by the block itself.
*/
`ifndef IRQ_CTL_CONSTS_SVH
`define IRQ_CTL_CONSTS_SVH

`define AXI_ADDR_W 8
`define AXI_DATA_W 32
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`define OFS_CORE_CONTROL 8'h00
`define OFS_CPU_STATUS 8'h04
`define OFS_INT_CONTROL_ONE 8'h08
`define OFS_INT_CONTROL_TWO 8'h0C
`define OFS_INT_FLAGS_ZERO 8'h10
`define OFS_INT_FLAGS_ONE 8'h14

`define REG_W 16
`define EXT_NUM 5

`define POS_PRIORITY_MSB 3
`define POS_PRIORITY_LOW 5
`define POS_NESTING_DISABLE 15
`define POS_DIV_ZERO 6
`define POS_DMA_ERR 5
`define POS_MATH_ERR 4
`define POS_ADDR_ERR 3
`define POS_STACK_ERR 2
`define POS_OSC_FAIL 1
`define POS_ALT_TABLE 15
`define POS_INSTR_DISABLE 14

`define CTRL_ONE_MASK 16'h807E
`define CTRL_TWO_MASK 16'h801F
`define FLAGS_ZERO_MASK 16'h7FFF
`define FLAGS_ONE_MASK 16'hFFFB

`define POS_EXT0_FLAG 0
`define POS_EXT1_FLAG 4
`define POS_EXT2_FLAG 13

`define RESET_REG 16'h0000
`define RESET_LEVEL_LOW 3'h0

`endif

// ===== irq_ctl_pkg.sv
/*
  Types of the interrupt control and flag block: register select,
  trap event bundle and the AXI4-Lite request and response bundles.
  Assumes the constants header sits in the same folder.
*/
`include "irq_ctl_consts.svh"

package irq_ctl_pkg;

  typedef enum logic [2:0] {
    SEL_CORE,
    SEL_STATUS,
    SEL_CTRL_ONE,
    SEL_CTRL_TWO,
    SEL_FLAGS_ZERO,
    SEL_FLAGS_ONE,
    SEL_NONE
  } reg_sel_t;

  typedef struct packed {
    logic osc_fail;
    logic addr_err;
    logic stack_err;
    logic math_err;
    logic div_zero;
    logic dma_err;
  } trap_events_t;

  typedef struct packed {
    logic awvalid;
    logic [`AXI_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [`AXI_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`AXI_ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [`AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

endpackage

// ===== irq_ctl.sv
/*
  Interrupt control and flag registers behind an AXI4-Lite slave: CPU
  priority level, nesting control, trap status, vector table select,
  external edge polarity and the first two flag registers.
  Assumes one clock, peripheral request and trap inputs that are
  one-cycle pulses on this clock, and asynchronous external pins.
*/
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
// What this block does
// - Priority msb at core control bit 3
// - Level is msb above three low bits
// - Priority msb readable, clear-only, resets zero
// - Nesting disable bit 15 of control one
// - Divide-by-zero cause at bit 6
// - DMA error trap flag at bit 5
// - Math error trap flag at bit 4
// - Address error trap flag at bit 3
// - Stack error trap flag at bit 2
// - Oscillator failure flag at bit 1
// - Unimplemented bits read as zero
// - Bit 15 of control two selects alternate table
// - Bit 14 shows instruction disable, read-only
// - Polarity bits pick negative or positive edge
// - Flags read/write, reset zero, show requests
// - Flags zero: DMA1 14, ADC1 13, DMA0 4
// - Flags zero: UART1 12/11, SPI1 10/9
// - Flags zero: timers, compare, capture, external 0
// - Flags one: UART2 15/14, external 2 13
// - Flags one: timers 12/11, compare 10/9, DMA2 8
// - Flags one: capture, ADC2, external 1, change, I2C
// - Hardware sets flags; software clears by writing
// - Low priority bits read-only while nesting disabled
// - Priority msb set blocks all user interrupts
`timescale 1ns/1ns
`include "irq_ctl_consts.svh"

module irq_ctl
  import irq_ctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire axi_req_t axi_req_i,
  output axi_rsp_t axi_rsp_o,
  input wire trap_events_t trap_i,
  input wire logic level_load_i,
  input wire logic [3:0] level_value_i,
  input wire logic instruction_disable_active_i,
  input wire logic [`REG_W-1:0] flags_zero_req_i,
  input wire logic [`REG_W-1:0] flags_one_req_i,
  input wire logic [`EXT_NUM-1:0] ext_pin_i,
  output logic [3:0] priority_level_o,
  output logic user_irq_block_o,
  output logic nesting_disable_o,
  output logic alternate_table_select_o,
  output logic [`EXT_NUM-1:0] ext_edge_o
);

  function automatic reg_sel_t decode(input logic [`AXI_ADDR_W-1:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a == `OFS_CORE_CONTROL) begin
      s = SEL_CORE;
    end else if (a == `OFS_CPU_STATUS) begin
      s = SEL_STATUS;
    end else if (a == `OFS_INT_CONTROL_ONE) begin
      s = SEL_CTRL_ONE;
    end else if (a == `OFS_INT_CONTROL_TWO) begin
      s = SEL_CTRL_TWO;
    end else if (a == `OFS_INT_FLAGS_ZERO) begin
      s = SEL_FLAGS_ZERO;
    end else if (a == `OFS_INT_FLAGS_ONE) begin
      s = SEL_FLAGS_ONE;
    end
    return s;
  endfunction

  function automatic logic [`REG_W-1:0] merge(
    input logic [`REG_W-1:0] old_v,
    input logic [`AXI_DATA_W-1:0] data,
    input logic [3:0] strb
  );
    logic [`REG_W-1:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (data[`REG_W-1:0] & m);
  endfunction

  // AXI4-Lite write channel state
  logic aw_held_q;
  logic w_held_q;
  logic [`AXI_ADDR_W-1:0] aw_addr_q;
  logic [`AXI_DATA_W-1:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  reg_sel_t wr_sel;
  reg_sel_t rd_sel;

  // Register state
  logic priority_msb_q;
  logic [2:0] priority_low_q;
  logic [`REG_W-1:0] ctrl_one_q;
  logic [`REG_W-1:0] ctrl_two_q;
  logic [`REG_W-1:0] flags_zero_q;
  logic [`REG_W-1:0] flags_one_q;
  logic [`REG_W-1:0] ctrl_one_set;
  logic [`REG_W-1:0] flags_zero_set;
  logic [`REG_W-1:0] flags_one_set;

  // External pin synchronisers and filtered levels
  logic [`EXT_NUM-1:0] ext_s1_q;
  logic [`EXT_NUM-1:0] ext_s2_q;
  logic [`EXT_NUM-1:0] ext_s3_q;
  logic [`EXT_NUM-1:0] ext_level_q;
  logic [`EXT_NUM-1:0] ext_level_d;
  logic [`EXT_NUM-1:0] ext_edge;

  assign wr_fire = aw_held_q && w_held_q && !axi_rsp_o.bvalid;
  assign wr_sel = decode(aw_addr_q);
  assign rd_sel = decode(axi_req_i.araddr);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      axi_rsp_o.awready <= 1'b1;
    end else if (ce_i) begin
      if (axi_req_i.awvalid && axi_rsp_o.awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= axi_req_i.awaddr;
        axi_rsp_o.awready <= 1'b0;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end else if (axi_rsp_o.bvalid && axi_req_i.bready) begin
        axi_rsp_o.awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= 4'h0;
      axi_rsp_o.wready <= 1'b1;
    end else if (ce_i) begin
      if (axi_req_i.wvalid && axi_rsp_o.wready) begin
        w_held_q <= 1'b1;
        w_data_q <= axi_req_i.wdata;
        w_strb_q <= axi_req_i.wstrb;
        axi_rsp_o.wready <= 1'b0;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end else if (axi_rsp_o.bvalid && axi_req_i.bready) begin
        axi_rsp_o.wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      axi_rsp_o.bvalid <= 1'b0;
      axi_rsp_o.bresp <= `AXI_RESP_OKAY;
    end else if (ce_i) begin
      if (wr_fire) begin
        axi_rsp_o.bvalid <= 1'b1;
        axi_rsp_o.bresp <= (wr_sel == SEL_NONE) ? `AXI_RESP_SLVERR
                                                 : `AXI_RESP_OKAY;
      end else if (axi_rsp_o.bvalid && axi_req_i.bready) begin
        axi_rsp_o.bvalid <= 1'b0;
      end
    end
  end

  // Read side: one read in flight, answered the cycle after arready
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      axi_rsp_o.arready <= 1'b1;
      axi_rsp_o.rvalid <= 1'b0;
      axi_rsp_o.rdata <= '0;
      axi_rsp_o.rresp <= `AXI_RESP_OKAY;
    end else if (ce_i) begin
      if (axi_req_i.arvalid && axi_rsp_o.arready) begin
        axi_rsp_o.arready <= 1'b0;
        axi_rsp_o.rvalid <= 1'b1;
        axi_rsp_o.rresp <= `AXI_RESP_OKAY;
        axi_rsp_o.rdata <= '0;
        case (rd_sel)
          SEL_CORE: begin
            axi_rsp_o.rdata[`POS_PRIORITY_MSB] <= priority_msb_q;
          end
          SEL_STATUS: begin
            axi_rsp_o.rdata[`POS_PRIORITY_LOW +: 3] <= priority_low_q;
          end
          SEL_CTRL_ONE: begin
            axi_rsp_o.rdata[`REG_W-1:0] <= ctrl_one_q & `CTRL_ONE_MASK;
          end
          SEL_CTRL_TWO: begin
            axi_rsp_o.rdata[`REG_W-1:0] <= ctrl_two_q & `CTRL_TWO_MASK;
            axi_rsp_o.rdata[`POS_INSTR_DISABLE] <=
              instruction_disable_active_i;
          end
          SEL_FLAGS_ZERO: begin
            axi_rsp_o.rdata[`REG_W-1:0] <=
              flags_zero_q & `FLAGS_ZERO_MASK;
          end
          SEL_FLAGS_ONE: begin
            axi_rsp_o.rdata[`REG_W-1:0] <= flags_one_q & `FLAGS_ONE_MASK;
          end
          default: begin
            axi_rsp_o.rresp <= `AXI_RESP_SLVERR;
          end
        endcase
      end else if (axi_rsp_o.rvalid && axi_req_i.rready) begin
        axi_rsp_o.rvalid <= 1'b0;
        axi_rsp_o.arready <= 1'b1;
      end
    end
  end

  // Core loads the level on trap or interrupt entry and return
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      priority_msb_q <= 1'b0;
      user_irq_block_o <= 1'b0;
    end else if (ce_i) begin
      if (level_load_i) begin
        priority_msb_q <= level_value_i[3];
        user_irq_block_o <= level_value_i[3];
      end else if (wr_fire && wr_sel == SEL_CORE && w_strb_q[0] &&
                   !w_data_q[`POS_PRIORITY_MSB]) begin
        // Software may only clear it, so traps stay unmaskable
        priority_msb_q <= 1'b0;
        user_irq_block_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      priority_low_q <= `RESET_LEVEL_LOW;
    end else if (ce_i) begin
      if (level_load_i) begin
        priority_low_q <= level_value_i[2:0];
      end else if (wr_fire && wr_sel == SEL_STATUS && w_strb_q[0] &&
                   !ctrl_one_q[`POS_NESTING_DISABLE]) begin
        priority_low_q <= w_data_q[`POS_PRIORITY_LOW +: 3];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      priority_level_o <= 4'h0;
    end else if (ce_i) begin
      if (level_load_i) begin
        priority_level_o <= level_value_i;
      end else begin
        priority_level_o <= {priority_msb_q, priority_low_q};
        if (wr_fire && wr_sel == SEL_CORE && w_strb_q[0] &&
            !w_data_q[`POS_PRIORITY_MSB]) begin
          priority_level_o[3] <= 1'b0;
        end
        if (wr_fire && wr_sel == SEL_STATUS && w_strb_q[0] &&
            !ctrl_one_q[`POS_NESTING_DISABLE]) begin
          priority_level_o[2:0] <= w_data_q[`POS_PRIORITY_LOW +: 3];
        end
      end
    end
  end

  // Trap status: set by the core, hardware set wins over a clear
  always_comb begin
    ctrl_one_set = '0;
    ctrl_one_set[`POS_DIV_ZERO] = trap_i.math_err & trap_i.div_zero;
    ctrl_one_set[`POS_DMA_ERR] = trap_i.dma_err;
    ctrl_one_set[`POS_MATH_ERR] = trap_i.math_err;
    ctrl_one_set[`POS_ADDR_ERR] = trap_i.addr_err;
    ctrl_one_set[`POS_STACK_ERR] = trap_i.stack_err;
    ctrl_one_set[`POS_OSC_FAIL] = trap_i.osc_fail;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_one_q <= `RESET_REG;
      nesting_disable_o <= 1'b0;
    end else if (ce_i) begin
      if (wr_fire && wr_sel == SEL_CTRL_ONE) begin
        ctrl_one_q <= (merge(ctrl_one_q, w_data_q, w_strb_q) |
                       ctrl_one_set) & `CTRL_ONE_MASK;
        if (w_strb_q[1]) begin
          nesting_disable_o <= w_data_q[`POS_NESTING_DISABLE];
        end
      end else begin
        ctrl_one_q <= ctrl_one_q | ctrl_one_set;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_two_q <= `RESET_REG;
      alternate_table_select_o <= 1'b0;
    end else if (ce_i) begin
      if (wr_fire && wr_sel == SEL_CTRL_TWO) begin
        // Instruction disable bit is never stored, only mirrored
        ctrl_two_q <= merge(ctrl_two_q, w_data_q, w_strb_q) &
                      `CTRL_TWO_MASK;
        if (w_strb_q[1]) begin
          alternate_table_select_o <= w_data_q[`POS_ALT_TABLE];
        end
      end
    end
  end

  // External pins: three stages, a change counts once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < `EXT_NUM; gi++) begin : g_ext
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          ext_s1_q[gi] <= 1'b0;
          ext_s2_q[gi] <= 1'b0;
          ext_s3_q[gi] <= 1'b0;
          ext_level_q[gi] <= 1'b0;
        end else if (ce_i) begin
          ext_s1_q[gi] <= ext_pin_i[gi];
          ext_s2_q[gi] <= ext_s1_q[gi];
          ext_s3_q[gi] <= ext_s2_q[gi];
          ext_level_q[gi] <= ext_level_d[gi];
        end
      end
      assign ext_level_d[gi] = (ext_s2_q[gi] == ext_s3_q[gi]) ?
                               ext_s3_q[gi] : ext_level_q[gi];
      assign ext_edge[gi] = ctrl_two_q[gi] ?
        (ext_level_q[gi] & ~ext_level_d[gi]) :
        (~ext_level_q[gi] & ext_level_d[gi]);
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_edge_o <= '0;
    end else if (ce_i) begin
      ext_edge_o <= ext_edge;
    end else begin
      ext_edge_o <= '0;
    end
  end

  // Peripheral requests steer the flag bits; external bits use edges
  always_comb begin
    flags_zero_set = flags_zero_req_i & `FLAGS_ZERO_MASK;
    flags_zero_set[`POS_EXT0_FLAG] = ext_edge[0];
    flags_one_set = flags_one_req_i & `FLAGS_ONE_MASK;
    flags_one_set[`POS_EXT1_FLAG] = ext_edge[1];
    flags_one_set[`POS_EXT2_FLAG] = ext_edge[2];
  end

  // Set wins over a software write in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_zero_q <= `RESET_REG;
    end else if (ce_i) begin
      if (wr_fire && wr_sel == SEL_FLAGS_ZERO) begin
        flags_zero_q <= (merge(flags_zero_q, w_data_q, w_strb_q) |
                         flags_zero_set) & `FLAGS_ZERO_MASK;
      end else begin
        flags_zero_q <= flags_zero_q | flags_zero_set;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_one_q <= `RESET_REG;
    end else if (ce_i) begin
      if (wr_fire && wr_sel == SEL_FLAGS_ONE) begin
        flags_one_q <= (merge(flags_one_q, w_data_q, w_strb_q) |
                        flags_one_set) & `FLAGS_ONE_MASK;
      end else begin
        flags_one_q <= flags_one_q | flags_one_set;
      end
    end
  end

endmodule

// ===== irq_ctl_props.sv
/*
  Port checker for the interrupt control and flag block.
  Assumes one clock; bound to every irq_ctl instance below.
*/
`timescale 1ns/1ns
`include "irq_ctl_consts.svh"
module irq_ctl_props
  import irq_ctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire axi_req_t axi_req_i,
  input wire axi_rsp_t axi_rsp_o,
  input wire logic ce_i,
  input wire logic level_load_i,
  input wire logic [3:0] level_value_i,
  input wire logic [3:0] priority_level_o,
  input wire logic user_irq_block_o,
  input wire logic nesting_disable_o,
  input wire logic [`EXT_NUM-1:0] ext_edge_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_block_msb: assert property (
    user_irq_block_o == priority_level_o[3])
    else $error("block flag differs from level msb");
  a_level_load: assert property (
    ce_i && level_load_i |=> priority_level_o == $past(level_value_i))
    else $error("loaded level not shown");
  a_msb_no_set: assert property (
    $rose(priority_level_o[3]) |-> $past(level_load_i))
    else $error("level msb set without core load");
  a_low_locked: assert property (
    $past(nesting_disable_o) && !$past(level_load_i)
      |-> $stable(priority_level_o[2:0]))
    else $error("low level bits moved while nesting disabled");
  a_edge_pulse: assert property (
    (ext_edge_o & $past(ext_edge_o)) == '0)
    else $error("edge pulse longer than one cycle");
  a_wr_answer: assert property (
    axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid
      && axi_rsp_o.wready |-> ##2 axi_rsp_o.bvalid)
    else $error("write response late");
  a_rd_answer: assert property (
    axi_req_i.arvalid && axi_rsp_o.arready
      |=> axi_rsp_o.rvalid && !axi_rsp_o.arready)
    else $error("read response late");
  a_ready_low: assert property (
    axi_rsp_o.bvalid |-> !axi_rsp_o.awready && !axi_rsp_o.wready)
    else $error("write ready during response");
endmodule

bind irq_ctl irq_ctl_props props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .axi_req_i(axi_req_i),
  .axi_rsp_o(axi_rsp_o), .ce_i(ce_i), .level_load_i(level_load_i),
  .level_value_i(level_value_i), .priority_level_o(priority_level_o),
  .user_irq_block_o(user_irq_block_o),
  .nesting_disable_o(nesting_disable_o), .ext_edge_o(ext_edge_o));

// ===== irq_src_model.sv
/*
  Model of the CPU core, trap sources, peripherals and external pins.
  Assumes the bench calls its tasks; all drives follow clk_i edges.
*/
`timescale 1ns/1ns
module irq_src_model
  import irq_ctl_pkg::*;
(
  input wire logic clk_i,
  output trap_events_t trap_o,
  output logic level_load_o,
  output logic [3:0] level_value_o,
  output logic instr_dis_o,
  output logic [15:0] fz_req_o,
  output logic [15:0] fo_req_o,
  output logic [4:0] pin_o
);
  initial begin
    trap_o = '0;
    level_load_o = 1'b0;
    level_value_o = 4'hF;
    instr_dis_o = 1'b0;
    fz_req_o = '0;
    fo_req_o = '0;
    pin_o = '0;
  end

  // Sources give one-cycle pulses; divide cause rides with math trap
  task automatic pulse(input trap_events_t t, input logic [15:0] z, o);
    @(posedge clk_i);
    trap_o <= t;
    fz_req_o <= z;
    fo_req_o <= o;
    @(posedge clk_i);
    trap_o <= '0;
    fz_req_o <= '0;
    fo_req_o <= '0;
  endtask

  // Value lines go stale after the load so nothing leans on them
  task automatic load(input logic [3:0] v);
    @(posedge clk_i);
    level_load_o <= 1'b1;
    level_value_o <= v;
    @(posedge clk_i);
    level_load_o <= 1'b0;
    level_value_o <= ~v;
  endtask

  task automatic set_dis(input logic v);
    @(posedge clk_i);
    instr_dis_o <= v;
  endtask

  task automatic set_pins(input logic [4:0] p);
    @(posedge clk_i);
    pin_o <= p;
  endtask
endmodule

// ===== tb.sv
/*
  Self-checking bench for irq_ctl over AXI4-Lite.
  Assumes irq_src_model stands in for core and interrupt sources.
*/
`timescale 1ns/1ns
`include "irq_ctl_consts.svh"
module tb
  import irq_ctl_pkg::*;
;
  localparam logic [7:0] CORE = `OFS_CORE_CONTROL;
  localparam logic [7:0] ST = `OFS_CPU_STATUS;
  localparam logic [7:0] C1 = `OFS_INT_CONTROL_ONE;
  localparam logic [7:0] C2 = `OFS_INT_CONTROL_TWO;
  localparam logic [7:0] F0 = `OFS_INT_FLAGS_ZERO;
  localparam logic [7:0] F1 = `OFS_INT_FLAGS_ONE;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce = 1'b1;
  axi_req_t req = '0;
  axi_rsp_t rsp;
  trap_events_t trap;
  logic lload, idis, blk, nest, alt;
  logic [3:0] lval, lvl;
  logic [15:0] fz, fo;
  logic [4:0] pins, edg;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;

  always #20 clk_i = ~clk_i;

  irq_ctl uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .axi_req_i(req), .axi_rsp_o(rsp), .trap_i(trap),
    .level_load_i(lload), .level_value_i(lval),
    .instruction_disable_active_i(idis), .flags_zero_req_i(fz),
    .flags_one_req_i(fo), .ext_pin_i(pins), .priority_level_o(lvl),
    .user_irq_block_o(blk), .nesting_disable_o(nest),
    .alternate_table_select_o(alt), .ext_edge_o(edg));
  irq_src_model src (.clk_i(clk_i), .trap_o(trap), .level_load_o(lload),
    .level_value_o(lval), .instr_dis_o(idis), .fz_req_o(fz),
    .fo_req_o(fo), .pin_o(pins));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit ap;
    bit wp;
    ap = 1;
    wp = 1;
    @(posedge clk_i);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (ap || wp) begin
      @(posedge clk_i);
      if (ap && rsp.awready) begin
        req.awvalid <= 1'b0;
        ap = 0;
      end
      if (wp && rsp.wready) begin
        req.wvalid <= 1'b0;
        wp = 0;
      end
    end
    while (!rsp.bvalid) @(posedge clk_i);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", `AXI_RESP_OKAY, 32'(r));
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_i);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge clk_i); while (!rsp.arready);
    req.arvalid <= 1'b0;
    while (!rsp.rvalid) @(posedge clk_i);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, e, d);
    chk("rresp", `AXI_RESP_OKAY, 32'(r));
  endtask

  task automatic t_reset();
    logic [7:0] ofs [6];
    logic [31:0] d;
    logic [1:0] r;
    ofs = '{CORE, ST, C1, C2, F0, F1};
    foreach (ofs[i]) rchk("reset value", ofs[i], 0);
    rd(8'h18, d, r);
    chk("unmapped rresp", `AXI_RESP_SLVERR, 32'(r));
    chk("unmapped rdata", 0, d);
    wr(8'h18, 32'hFFFF, r);
    chk("unmapped bresp", `AXI_RESP_SLVERR, 32'(r));
    $display("test reset done");
  endtask

  task automatic t_ctrl();
    w(C1, 32'hFFFF_FFFF);
    rchk("ctl1 bits", C1, 32'h807E);
    chk("nesting out", 1, 32'(nest));
    w(ST, 32'hE0);
    rchk("locked low", ST, 0);
    w(C1, 0);
    chk("nesting out", 0, 32'(nest));
    w(ST, 32'hE0);
    rchk("low bits", ST, 32'hE0);
    rchk("msb at 7", CORE, 0);
    chk("level", 7, 32'(lvl));
    chk("block", 0, 32'(blk));
    w(C2, 32'hFFFF_FFFF);
    rchk("ctl2 bits", C2, 32'h801F);
    chk("alt out", 1, 32'(alt));
    src.set_dis(1'b1);
    rchk("dis bit", C2, 32'hC01F);
    src.set_dis(1'b0);
    w(C2, 0);
    chk("alt out", 0, 32'(alt));
    $display("test control done");
  endtask

  task automatic t_msb();
    src.load(4'hA);
    rchk("msb", CORE, 32'h8);
    rchk("low of A", ST, 32'h40);
    chk("level", 32'hA, 32'(lvl));
    chk("block", 1, 32'(blk));
    w(CORE, 0);
    rchk("msb clear", CORE, 0);
    chk("block", 0, 32'(blk));
    w(CORE, 32'h8);
    rchk("msb no set", CORE, 0);
    $display("test priority done");
  endtask

  task automatic t_traps();
    trap_events_t tv [6];
    logic [31:0] ex [6];
    tv = '{6'b000110, 6'b000100, 6'b000001, 6'b010000, 6'b001000,
           6'b100000};
    ex = '{32'h50, 32'h10, 32'h20, 32'h08, 32'h04, 32'h02};
    foreach (tv[i]) begin
      src.pulse(tv[i], '0, '0);
      rchk("trap", C1, ex[i]);
      w(C1, 0);
    end
    $display("test traps done");
  endtask

  task automatic t_flags();
    for (int i = 0; i < 16; i++) begin
      logic [15:0] b;
      b = 16'h1 << i;
      src.pulse('0, b, b);
      rchk("flags0", F0, {16'h0, b & 16'h7FFE});
      rchk("flags1", F1, {16'h0, b & 16'hDFEB});
      w(F0, 0);
      w(F1, 0);
    end
    w(F0, 32'hFFFF);
    rchk("sw set", F0, 32'h7FFF);
    w(F0, 0);
    rchk("sw clear", F0, 0);
    $display("test flags done");
  endtask

  task automatic ext_run(input logic [4:0] p, input logic [4:0] e);
    logic [4:0] seen;
    seen = '0;
    src.set_pins(p);
    repeat (10) begin
      @(posedge clk_i);
      seen |= edg;
    end
    chk("edges", 32'(e), 32'(seen));
    rchk("ext flag0", F0, {31'h0, e[0]});
    rchk("ext flag1", F1, {18'h0, e[2], 8'h0, e[1], 4'h0});
    w(F0, 0);
    w(F1, 0);
  endtask

  task automatic t_ext();
    ext_run(5'h1F, 5'h1F);
    ext_run(5'h00, 5'h00);
    w(C2, 32'h1F);
    ext_run(5'h1F, 5'h00);
    ext_run(5'h00, 5'h1F);
    $display("test external done");
  endtask

  // Enable low: requests, traps and a core load must all be ignored
  task automatic t_hold();
    @(posedge clk_i);
    ce <= 1'b0;
    src.pulse(6'b000100, 16'h0100, 16'h0100);
    src.load(4'hF);
    chk("held level", 32'h2, 32'(lvl));
    @(posedge clk_i);
    ce <= 1'b1;
    rchk("held traps", C1, 0);
    rchk("held flags0", F0, 0);
    rchk("held flags1", F1, 0);
    $display("test hold done");
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_ctrl();
    t_msb();
    t_traps();
    t_flags();
    t_ext();
    t_hold();
    finish_test();
  end
endmodule
